// >>> src/rps_pkg.sv
package rps_pkg;
  // ==========================================================================
  // Clock and timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned OV_EXIT_MS = 100;
  localparam int unsigned HICCUP_S = 3;
  localparam int unsigned LL_DLY_10_S = 10;
  localparam int unsigned LL_DLY_20_S = 20;
  localparam int unsigned LL_DLY_30_S = 30;
  localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
  localparam int unsigned TICK_CYCLES = MS_CYCLES;
  localparam int unsigned OV_EXIT_TICKS = OV_EXIT_MS;
  localparam int unsigned HICCUP_TICKS = HICCUP_S * 1000;
  localparam int unsigned LL_10_TICKS = LL_DLY_10_S * 1000;
  localparam int unsigned LL_20_TICKS = LL_DLY_20_S * 1000;
  localparam int unsigned LL_30_TICKS = LL_DLY_30_S * 1000;
  localparam int unsigned TMR_W = 16;

  // ==========================================================================
  // Analog thresholds (millivolt / milliamp codes)
  localparam int unsigned VOUT_W = 11;
  localparam int unsigned MV_W = 16;
  localparam logic [MV_W-1:0] VOUT_BASE_MV = 16'h0b90;
  localparam logic [MV_W-1:0] VOUT_STEP_MV = 16'h0014;
  localparam int unsigned OV_PCT = 108;
  localparam logic [MV_W-1:0] UV_FAULT_MV = 16'h0bb8;
  localparam logic [MV_W-1:0] LL_HEADROOM_MV = 16'h01f4;
  localparam logic [MV_W-1:0] LL_VOUT_MAX_MV = 16'h1770;
  localparam logic [MV_W-1:0] LL_CURR_MA = 16'h0005;
  localparam logic [MV_W-1:0] COMP_REF_MA = 16'h0960;
  localparam logic [MV_W-1:0] COMP_STEP_MV = 16'h0064;
  localparam int unsigned SENSE_REF_MOHM = 10;

  // ==========================================================================
  // Status codes
  localparam logic [2:0] ST_RESET = 3'h0;
  localparam logic [2:0] ST_SOFT = 3'h1;
  localparam logic [2:0] ST_REG = 3'h2;
  localparam logic [2:0] ST_RETRY = 3'h3;
  localparam logic [2:0] ST_LLOFF = 3'h4;
  localparam int unsigned FSW_KHZ_DEFAULT = 500;

  typedef enum logic [2:0] {
    RPS_IDLE, RPS_RESET, RPS_DELAY, RPS_SOFT, RPS_REG, RPS_RETRY, RPS_LLOFF
  } rps_state_t;
endpackage : rps_pkg

// >>> src/rps_sync3.sv
`timescale 1ns/1ps
module rps_sync3 (
  input wire logic clk,
  input wire logic resetn,
  input wire logic d,
  output logic q
);
  logic s1_q, s2_q, s3_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      q <= 1'b1;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        q <= s3_q;
      end
    end
  end
endmodule : rps_sync3

// >>> src/rps_tick.sv
`timescale 1ns/1ps
module rps_tick #(
  parameter int unsigned CYCLES = rps_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  output logic tick
);
  logic [$clog2(CYCLES+1)-1:0] cnt_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else if (cnt_q == ($clog2(CYCLES+1))'(CYCLES - 1)) begin
      cnt_q <= '0;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule : rps_tick

// >>> src/rps_supervisor.sv
`timescale 1ns/1ps
// Functional notes
// R01 - Port overvoltage above 108% stops switching immediately
// R02 - Overvoltage beyond 100ms exits to idle
// R03 - Cable compensation raises set point with current
// R04 - Step defined at 2.4A, 10 milliohm
// R05 - Level code 0 off, 1-3 100-300mV
// R06 - Light load stops switching, enters light-load state
// R07 - Light load needs reverse, buck, headroom, <6V
// R08 - Light load enable bit gates function
// R09 - Low load means current below 5mA
// R10 - Low current must outlast 10/20/30s delay
// R11 - Light-load state holds converter off until reentry
// R12 - Host restarts by toggling pin or registers
// R13 - Voltage code change retargets output on fly
// R14 - Slew select sets ramp between settings
// R15 - Step-down sink 70mA until back in regulation
// R16 - Overvoltage sink active during any overvoltage
// R17 - Status codes 0-4, never 5-7
// R18 - Status reads zero outside reverse mode
// R19 - Temperature outside window forces reset state (code leaves the light-load state unchanged)
// R20 - Monitoring active when disable bit zero
// R21 - Same threshold fields as normal charging
// R22 - Switching frequency fixed, software cannot change
// R23 - Output below 3V: 3s retry, restart
// R24 - Enable delay then soft start then regulate
// R25 - Idle bit, enable clear, or pin release exit
// R26 - Overvoltage timer restarts when condition clears
// R27 - Light-load timer resets on any break
module rps_supervisor #(
  parameter int unsigned TICK_CYCLES = rps_pkg::TICK_CYCLES,
  parameter int unsigned HICCUP_TICKS = rps_pkg::HICCUP_TICKS,
  parameter int unsigned LL_10_TICKS = rps_pkg::LL_10_TICKS,
  parameter int unsigned LL_20_TICKS = rps_pkg::LL_20_TICKS,
  parameter int unsigned LL_30_TICKS = rps_pkg::LL_30_TICKS,
  parameter int unsigned OV_EXIT_TICKS = rps_pkg::OV_EXIT_TICKS,
  parameter int unsigned FSW_KHZ = rps_pkg::FSW_KHZ_DEFAULT
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic reverse_request_pin_n,
  input wire logic high_impedance_idle,
  input wire logic reverse_mode_enable_bit,
  input wire logic pin_override_bit,
  input wire logic [1:0] cable_drop_comp_level,
  input wire logic light_load_off_enable,
  input wire logic [1:0] light_load_off_delay,
  input wire logic [rps_pkg::VOUT_W-1:0] reverse_out_voltage_code,
  input wire logic out_voltage_source_select,
  input wire logic [1:0] out_voltage_slew_select,
  input wire logic stepdown_sink_enable,
  input wire logic overvolt_sink_enable,
  input wire logic thermistor_monitor_disable,
  input wire logic [1:0] battery_hot_threshold,
  input wire logic battery_cold_threshold,
  input wire logic temp_too_hot,
  input wire logic temp_too_cold,
  input wire logic [1:0] enable_delay_ticks,
  input wire logic soft_start_done,
  input wire logic in_regulation,
  input wire logic buck_operation,
  input wire logic [rps_pkg::MV_W-1:0] port_mv,
  input wire logic [rps_pkg::MV_W-1:0] battery_mv,
  input wire logic [rps_pkg::MV_W-1:0] out_current_ma,
  output logic reverse_active,
  output logic switching_enable,
  output logic [rps_pkg::MV_W-1:0] regulation_target_mv,
  output logic [rps_pkg::MV_W-1:0] comp_boost_mv,
  output logic [1:0] slew_rate_sel,
  output logic stepdown_sink_on,
  output logic overvolt_sink_on,
  output logic [2:0] reverse_fsm_state,
  output logic [1:0] temp_hot_sel,
  output logic temp_cold_sel,
  output logic [10:0] fsw_khz
);
  // ==========================================================================
  // Input conditioning and time base
  logic pin_n_s;
  logic tick;
  rps_sync3 u_pin (
    .clk(clk),
    .resetn(resetn),
    .d(reverse_request_pin_n),
    .q(pin_n_s)
  );
  rps_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .clk(clk),
    .resetn(resetn),
    .tick(tick)
  );

  rps_pkg::rps_state_t st_q;
  logic [rps_pkg::TMR_W-1:0] ov_tmr_q, st_tmr_q, ll_tmr_q;
  logic [rps_pkg::MV_W-1:0] set_mv_q;
  logic [rps_pkg::VOUT_W-1:0] code_q;

  // ==========================================================================
  // Set point and comparators
  logic [rps_pkg::MV_W-1:0] code_mv;
  logic [rps_pkg::MV_W+7:0] ov_lhs, ov_rhs;
  logic ov_now, uv_now, ll_cond, ll_low, temp_bad, req_on, req_off;
  logic [rps_pkg::TMR_W-1:0] ll_limit;
  always_comb begin
    code_mv = rps_pkg::VOUT_BASE_MV
      + rps_pkg::MV_W'(32'(reverse_out_voltage_code) * 32'(rps_pkg::VOUT_STEP_MV));
  end
  // Threshold at 108% of programmed voltage, computed without division
  assign ov_lhs = 24'(port_mv) * 24'd100; // R01
  assign ov_rhs = 24'(set_mv_q) * 24'(rps_pkg::OV_PCT); // R01
  assign ov_now = (ov_lhs > ov_rhs);
  assign uv_now = (port_mv < rps_pkg::UV_FAULT_MV); // R23
  assign ll_low = (out_current_ma < rps_pkg::LL_CURR_MA); // R09
  assign ll_cond = light_load_off_enable && (st_q == rps_pkg::RPS_REG) && buck_operation // R07 R08
    && (battery_mv >= port_mv + rps_pkg::LL_HEADROOM_MV)
    && (port_mv < rps_pkg::LL_VOUT_MAX_MV) && ll_low;
  assign temp_bad = !thermistor_monitor_disable && (temp_too_hot || temp_too_cold); // R19 R20
  assign req_on = !high_impedance_idle && reverse_mode_enable_bit
    && (!pin_n_s || pin_override_bit);
  assign req_off = high_impedance_idle || !reverse_mode_enable_bit // R25
    || (pin_n_s && !pin_override_bit);
  always_comb begin
    unique case (light_load_off_delay)
      2'h0: ll_limit = rps_pkg::TMR_W'(LL_10_TICKS); // R10
      2'h1: ll_limit = rps_pkg::TMR_W'(LL_20_TICKS);
      default: ll_limit = rps_pkg::TMR_W'(LL_30_TICKS);
    endcase
  end

  // ==========================================================================
  // Overvoltage qualification timer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ov_tmr_q <= '0;
    end else if (!ov_now || st_q == rps_pkg::RPS_IDLE) begin
      ov_tmr_q <= '0; // R26
    end else if (tick && ov_tmr_q != rps_pkg::TMR_W'(OV_EXIT_TICKS)) begin
      ov_tmr_q <= ov_tmr_q + 1'b1; // R02
    end
  end

  // ==========================================================================
  // Light-load delay timer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ll_tmr_q <= '0;
    end else if (!ll_cond) begin
      ll_tmr_q <= '0; // R27
    end else if (tick && ll_tmr_q != ll_limit) begin
      ll_tmr_q <= ll_tmr_q + 1'b1;
    end
  end

  // ==========================================================================
  // Reverse-mode state machine
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= rps_pkg::RPS_IDLE;
      st_tmr_q <= '0;
    end else if (st_q == rps_pkg::RPS_IDLE) begin
      st_tmr_q <= '0;
      if (req_on) begin
        st_q <= rps_pkg::RPS_RESET;
      end
    end else if (req_off || ov_tmr_q == rps_pkg::TMR_W'(OV_EXIT_TICKS)) begin
      st_q <= rps_pkg::RPS_IDLE; // R02 R25 R12
      st_tmr_q <= '0;
    end else if (temp_bad) begin
      if (st_q != rps_pkg::RPS_LLOFF) begin
        st_q <= rps_pkg::RPS_RESET; // R19
      end
      st_tmr_q <= '0;
    end else begin
      unique case (st_q)
        rps_pkg::RPS_RESET: begin
          st_tmr_q <= '0;
          st_q <= rps_pkg::RPS_DELAY;
        end
        rps_pkg::RPS_DELAY: begin
          if (st_tmr_q >= rps_pkg::TMR_W'(enable_delay_ticks)) begin
            st_q <= rps_pkg::RPS_SOFT; // R24
            st_tmr_q <= '0;
          end else if (tick) begin
            st_tmr_q <= st_tmr_q + 1'b1;
          end
        end
        rps_pkg::RPS_SOFT: begin
          if (soft_start_done) begin
            st_q <= rps_pkg::RPS_REG; // R24
          end
        end
        rps_pkg::RPS_REG: begin
          if (uv_now) begin
            st_q <= rps_pkg::RPS_RETRY; // R23
            st_tmr_q <= '0;
          end else if (ll_tmr_q == ll_limit) begin
            st_q <= rps_pkg::RPS_LLOFF; // R06 R10
          end
        end
        rps_pkg::RPS_RETRY: begin
          if (st_tmr_q == rps_pkg::TMR_W'(HICCUP_TICKS)) begin
            st_q <= rps_pkg::RPS_RESET; // R23
            st_tmr_q <= '0;
          end else if (tick) begin
            st_tmr_q <= st_tmr_q + 1'b1;
          end
        end
        rps_pkg::RPS_LLOFF: begin
          st_q <= rps_pkg::RPS_LLOFF; // R11
        end
        default: begin
          st_q <= rps_pkg::RPS_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Output voltage tracking and step-down sink
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      set_mv_q <= rps_pkg::VOUT_BASE_MV;
      code_q <= '0;
      stepdown_sink_on <= 1'b0;
    end else begin
      if (!out_voltage_source_select) begin
        set_mv_q <= code_mv; // R13
        code_q <= reverse_out_voltage_code;
      end
      if (!stepdown_sink_enable || st_q == rps_pkg::RPS_IDLE) begin
        stepdown_sink_on <= 1'b0;
      end else if (!out_voltage_source_select && reverse_out_voltage_code < code_q) begin
        stepdown_sink_on <= 1'b1; // R15
      end else if (in_regulation) begin
        stepdown_sink_on <= 1'b0; // R15
      end
    end
  end

  // ==========================================================================
  // Registered outputs
  logic on_state;
  logic [rps_pkg::MV_W+1:0] comp_full;
  assign on_state = (st_q == rps_pkg::RPS_SOFT) || (st_q == rps_pkg::RPS_REG);
  // Boost = level*100mV * I/2.4A; sense resistor scaling is applied by the analog loop
  assign comp_full = 18'((32'(cable_drop_comp_level) * 32'(rps_pkg::COMP_STEP_MV)
    * 32'(out_current_ma)) / 32'(rps_pkg::COMP_REF_MA)); // R03 R04 R05
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reverse_active <= 1'b0;
      switching_enable <= 1'b0;
      regulation_target_mv <= '0;
      comp_boost_mv <= '0;
      slew_rate_sel <= '0;
      overvolt_sink_on <= 1'b0;
      reverse_fsm_state <= rps_pkg::ST_RESET;
      temp_hot_sel <= '0;
      temp_cold_sel <= 1'b0;
      fsw_khz <= '0;
    end else begin
      reverse_active <= (st_q != rps_pkg::RPS_IDLE);
      switching_enable <= on_state && !ov_now; // R01 R26
      comp_boost_mv <= (comp_full > 18'(16'hffff)) ? 16'hffff : comp_full[15:0];
      regulation_target_mv <= set_mv_q + comp_boost_mv; // R03
      slew_rate_sel <= out_voltage_slew_select; // R14
      overvolt_sink_on <= overvolt_sink_enable && ov_now
        && (st_q != rps_pkg::RPS_IDLE); // R16
      temp_hot_sel <= battery_hot_threshold; // R21
      temp_cold_sel <= battery_cold_threshold; // R21
      fsw_khz <= 11'(FSW_KHZ); // R22
      unique case (st_q)
        rps_pkg::RPS_SOFT: reverse_fsm_state <= rps_pkg::ST_SOFT; // R17
        rps_pkg::RPS_REG: reverse_fsm_state <= rps_pkg::ST_REG;
        rps_pkg::RPS_RETRY: reverse_fsm_state <= rps_pkg::ST_RETRY;
        rps_pkg::RPS_LLOFF: reverse_fsm_state <= rps_pkg::ST_LLOFF;
        default: reverse_fsm_state <= rps_pkg::ST_RESET; // R18
      endcase
    end
  end

  // ==========================================================================
  // Checks
  sequence s_ov_held;
    ov_now && st_q != rps_pkg::RPS_IDLE;
  endsequence
  property p_ov_stop;
    @(posedge clk) disable iff (!resetn) s_ov_held |=> !switching_enable;
  endproperty
  a_ov_stop: assert property (p_ov_stop) else $error("switching on during overvoltage"); // R01
  property p_ov_exit;
    @(posedge clk) disable iff (!resetn)
      ov_tmr_q == rps_pkg::TMR_W'(OV_EXIT_TICKS) && st_q != rps_pkg::RPS_IDLE
      |=> st_q == rps_pkg::RPS_IDLE;
  endproperty
  a_ov_exit: assert property (p_ov_exit) else $error("no exit after overvoltage"); // R02
  property p_ov_clr;
    @(posedge clk) disable iff (!resetn) !ov_now |=> ov_tmr_q == '0;
  endproperty
  a_ov_clr: assert property (p_ov_clr) else $error("overvoltage timer kept"); // R26
  property p_ll_clr;
    @(posedge clk) disable iff (!resetn) !ll_cond |=> ll_tmr_q == '0;
  endproperty
  a_ll_clr: assert property (p_ll_clr) else $error("light-load timer kept"); // R27
  property p_ll_hold;
    @(posedge clk) disable iff (!resetn)
      st_q == rps_pkg::RPS_LLOFF && !req_off && ov_tmr_q != rps_pkg::TMR_W'(OV_EXIT_TICKS)
      |=> st_q == rps_pkg::RPS_LLOFF;
  endproperty
  a_ll_hold: assert property (p_ll_hold) else $error("left light-load state"); // R11
  property p_status_valid;
    @(posedge clk) disable iff (!resetn) reverse_fsm_state <= rps_pkg::ST_LLOFF;
  endproperty
  a_status_valid: assert property (p_status_valid) else $error("illegal status"); // R17
  property p_status_idle;
    @(posedge clk) disable iff (!resetn)
      st_q == rps_pkg::RPS_IDLE ##1 st_q == rps_pkg::RPS_IDLE |-> reverse_fsm_state == '0;
  endproperty
  a_status_idle: assert property (p_status_idle) else $error("status not zero"); // R18
  property p_exit_req;
    @(posedge clk) disable iff (!resetn)
      req_off && st_q != rps_pkg::RPS_IDLE |=> st_q == rps_pkg::RPS_IDLE;
  endproperty
  a_exit_req: assert property (p_exit_req) else $error("no exit on request"); // R25
  property p_temp;
    @(posedge clk) disable iff (!resetn)
      temp_bad && !req_off && (st_q == rps_pkg::RPS_REG || st_q == rps_pkg::RPS_SOFT)
      && ov_tmr_q != rps_pkg::TMR_W'(OV_EXIT_TICKS) |=> st_q == rps_pkg::RPS_RESET;
  endproperty
  a_temp: assert property (p_temp) else $error("no reset on temperature"); // R19
  property p_ovsink;
    @(posedge clk) disable iff (!resetn)
      (s_ov_held and overvolt_sink_enable) ##1 overvolt_sink_enable |-> overvolt_sink_on;
  endproperty
  a_ovsink: assert property (p_ovsink) else $error("overvoltage sink off"); // R16
endmodule : rps_supervisor

// >>> bench/rps_host_model.sv
`timescale 1ns/1ps
// ==========================================
// Host side: enable pin and mode bits
module rps_host_model (
  input wire logic clk,
  output logic pin_n,
  output logic idle,
  output logic en,
  output logic ovr
);
  initial begin
    pin_n = 1'b1;
    idle = 1'b0;
    en = 1'b0;
    ovr = 1'b0;
  end

  // Enter by the pin, or by the override bit with the pin released
  task automatic enter(input logic by_pin);
    @(negedge clk);
    idle <= 1'b0;
    en <= 1'b1;
    ovr <= !by_pin;
    pin_n <= !by_pin;
  endtask : enter

  // Leave by the idle bit, the enable bit or the pin
  task automatic leave(input int how);
    @(negedge clk);
    case (how)
      0: idle <= 1'b1;
      1: en <= 1'b0;
      default: begin
        pin_n <= 1'b1;
        ovr <= 1'b0;
      end
    endcase
  endtask : leave
endmodule : rps_host_model

// >>> bench/rps_supervisor_tb.sv
`timescale 1ns/1ps
// ==========================================
// Self-checking bench for the reverse-mode supervisor
module rps_supervisor_tb;
  localparam int TK = 10;
  localparam int HT = 30;
  localparam int OVT = 20;
  localparam int LL1 = 20;
  typedef struct {
    int s;
    logic [15:0] v;
  } rps_note_t;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic pin_n, idle, en, ovr;
  logic ll_en = 1'b0, src = 1'b0, sd_en = 1'b0, ov_en = 1'b0, th_dis = 1'b0;
  logic cold = 1'b0, t_hot = 1'b0, t_cold = 1'b0, ss_done = 1'b0, in_reg = 1'b1, buck = 1'b0;
  logic [1:0] comp = 2'h0, ll_dly = 2'h0, slew = 2'h0, hot = 2'h0, dly = 2'h0;
  logic [10:0] code = 11'h064;
  logic [15:0] port = 16'h1360, bat = 16'h1770, cur = 16'h03e8, p = 16'h1360;
  logic act, sw, sdn, sov, csel;
  logic [15:0] tgt, boost;
  logic [1:0] slw, hsel;
  logic [2:0] st;
  logic [10:0] fsw;
  integer seed = 32'h82fd;
  int fail_count = 0;
  int tests_run = 0;
  rps_note_t q[$];
  rps_note_t n;
  event res_ev;
  string nm[11] = '{"state", "active", "switching", "target", "boost", "sink_down",
    "sink_ov", "fsw", "hot_sel", "slew", "cold_sel"};

  always #10 clk = ~clk;

  rps_host_model u_host (.clk(clk), .pin_n(pin_n), .idle(idle), .en(en), .ovr(ovr));

  rps_supervisor #(.TICK_CYCLES(TK), .HICCUP_TICKS(HT), .LL_10_TICKS(LL1),
    .LL_20_TICKS(2 * LL1), .LL_30_TICKS(3 * LL1), .OV_EXIT_TICKS(OVT)) u_rps_supervisor (
    .clk(clk), .resetn(resetn), .reverse_request_pin_n(pin_n), .high_impedance_idle(idle),
    .reverse_mode_enable_bit(en), .pin_override_bit(ovr), .cable_drop_comp_level(comp),
    .light_load_off_enable(ll_en), .light_load_off_delay(ll_dly),
    .reverse_out_voltage_code(code), .out_voltage_source_select(src),
    .out_voltage_slew_select(slew), .stepdown_sink_enable(sd_en),
    .overvolt_sink_enable(ov_en), .thermistor_monitor_disable(th_dis),
    .battery_hot_threshold(hot), .battery_cold_threshold(cold), .temp_too_hot(t_hot),
    .temp_too_cold(t_cold), .enable_delay_ticks(dly), .soft_start_done(ss_done),
    .in_regulation(in_reg), .buck_operation(buck), .port_mv(port), .battery_mv(bat),
    .out_current_ma(cur), .reverse_active(act), .switching_enable(sw),
    .regulation_target_mv(tgt), .comp_boost_mv(boost), .slew_rate_sel(slw),
    .stepdown_sink_on(sdn), .overvolt_sink_on(sov), .reverse_fsm_state(st),
    .temp_hot_sel(hsel), .temp_cold_sel(csel), .fsw_khz(fsw));

  // ==========================================
  // Result watcher
  function automatic logic [15:0] obs(input int s);
    case (s)
      0: return {13'h0, st};
      1: return {15'h0, act};
      2: return {15'h0, sw};
      3: return tgt;
      4: return boost;
      5: return {15'h0, sdn};
      6: return {15'h0, sov};
      7: return {5'h0, fsw};
      8: return {14'h0, hsel};
      9: return {14'h0, slw};
      default: return {15'h0, csel};
    endcase
  endfunction : obs

  always begin
    @(res_ev);
    while (q.size() > 0) begin
      n = q.pop_front();
      tests_run++;
      if (obs(n.s) !== n.v) begin
        fail_count++;
        $display("wrong value %s: expected %h seen %h", nm[n.s], n.v, obs(n.s));
      end
    end
  end

  // ==========================================
  // Helpers
  task automatic chk(input int s, input logic [15:0] v);
    rps_note_t t;
    t.s = s;
    t.v = v;
    q.push_back(t);
    ->res_ev;
  endtask : chk

  task automatic cyc(input int c);
    repeat (c) @(negedge clk);
  endtask : cyc

  // Bounded wait for an output value, then note it
  task automatic wt(input int s, input logic [15:0] v, input int lim);
    int i;
    i = 0;
    while (obs(s) !== v && i < lim) begin
      @(negedge clk);
      i++;
    end
    chk(s, v);
  endtask : wt

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end

  // ==========================================
  // Scenarios
  initial begin
    cyc(20);
    resetn = 1'b1;
    hot = 2'($random(seed));
    cold = 1'($random(seed));
    slew = 2'($random(seed));
    cyc(3);
    chk(7, 16'h01f4);
    chk(0, 16'h0000);
    u_host.enter(1'b1);
    wt(0, 16'h1, 20);
    ss_done = 1'b1;
    wt(0, 16'h2, 10);
    chk(8, {14'h0, hot});
    chk(10, {15'h0, cold});
    chk(9, {14'h0, slew});
    for (int k = 0; k < 4; k++) begin
      code = 11'h064 + 11'($random(seed) & 511);
      p = 16'h0b90 + 16'h0014 * 16'(code);
      port = p;
      cyc(4);
      chk(3, p);
    end
    src = 1'b1;
    code = code + 11'h032;
    cyc(4);
    chk(3, p);
    src = 1'b0;
    code = code - 11'h032;
    cur = 16'h0960;
    for (int k = 0; k < 4; k++) begin
      comp = 2'(k);
      cyc(4);
      chk(4, 16'(100 * k));
    end
    cur = 16'h04b0;
    cyc(4);
    chk(4, 16'h0096);
    comp = 2'h0;
    sd_en = 1'b1;
    in_reg = 1'b0;
    code = code - 11'h00a;
    p = p - 16'h00c8;
    port = p;
    cyc(4);
    chk(5, 16'h1);
    in_reg = 1'b1;
    cyc(4);
    chk(5, 16'h0);
    ov_en = 1'b1;
    port = {p[14:0], 1'b0};
    cyc(3);
    chk(2, 16'h0);
    chk(6, 16'h1);
    cyc(OVT * TK / 2);
    port = p;
    cyc(4);
    chk(2, 16'h1);
    chk(6, 16'h0);
    port = {p[14:0], 1'b0};
    cyc(OVT * TK - 20);
    chk(1, 16'h1);
    wt(1, 16'h0, 40);
    port = p;
    u_host.leave(2);
    cyc(4);
    u_host.enter(1'b0);
    wt(0, 16'h2, 40);
    port = 16'h07d0;
    wt(0, 16'h3, 20);
    cyc(2);
    chk(2, 16'h0);
    cyc(HT * TK - 30);
    chk(0, 16'h3);
    port = p;
    wt(0, 16'h2, HT * TK);
    t_hot = 1'b1;
    wt(0, 16'h0, 10);
    chk(1, 16'h1);
    th_dis = 1'b1;
    wt(0, 16'h2, 20);
    th_dis = 1'b0;
    t_hot = 1'b0;
    t_cold = 1'b1;
    wt(0, 16'h0, 10);
    t_cold = 1'b0;
    wt(0, 16'h2, 20);
    code = 11'h064;
    p = 16'h1360;
    port = p;
    buck = 1'b1;
    cur = 16'h0002;
    cyc(3 * LL1 * TK + 50);
    chk(0, 16'h2);
    ll_en = 1'b1;
    bat = 16'h14b4;
    cyc(LL1 * TK + 50);
    chk(0, 16'h2);
    bat = 16'h1770;
    for (int d = 0; d < 3; d++) begin
      ll_dly = 2'(d);
      cur = 16'h03e8;
      cyc(2);
      cur = 16'h0002;
      cyc(LL1 * TK / 2);
      cur = 16'h03e8;
      cyc(1);
      cur = 16'h0002;
      cyc(LL1 * (d + 1) * TK - 30);
      chk(0, 16'h2);
      wt(0, 16'h4, 80);
      cyc(20);
      chk(2, 16'h0);
      chk(0, 16'h4);
      cur = 16'h03e8;
      u_host.leave(2);
      wt(1, 16'h0, 20);
      u_host.enter(1'b1);
      wt(0, 16'h2, 40);
    end
    for (int k = 0; k < 3; k++) begin
      u_host.leave(k);
      wt(1, 16'h0, 20);
      cyc(3);
      chk(0, 16'h0);
      dly = 2'($random(seed));
      u_host.enter(1'b1);
      wt(0, 16'h2, 80);
    end
    cyc(2);
    tally_and_finish();
  end
endmodule : rps_supervisor_tb
